// file: hdl/wss_consts.svh
// constants of the waveform sequence slots block: addresses, fields, resets, timing
// assumes a 125 MHz device clock and byte-wide register addresses
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH
`define WSS_ADDR_FIRST   8'h0F
`define WSS_ADDR_ENTRY3  8'h11
`define WSS_ADDR_ENTRY4  8'h12
`define WSS_ADDR_LAST    8'h16
`define WSS_ENTRY_RST    8'h00
`define WSS_FLAG_BIT     7
`define WSS_UNIT_MS      10
`define WSS_CLK_KHZ      125000
`define WSS_UNIT_CYC     (`WSS_UNIT_MS * `WSS_CLK_KHZ)
`endif

// file: hdl/wss_pkg.sv
// types of the waveform sequence slots block
// assumes wss_consts.svh holds the addresses, fields, resets and timing; the state codes are set here
package wss_pkg;
	typedef enum logic [3:0] {
		WSS_IDLE  = 4'h1,
		WSS_FETCH = 4'h2,
		WSS_PLAY  = 4'h4,
		WSS_WAIT  = 4'h8
	} wss_state_t;
	typedef logic [7:0] wss_entry_t;
endpackage : wss_pkg

// file: hdl/wss_tick_if.sv
// link between the sequencer and its delay-unit prescaler
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface wss_tick_if;
	logic restart;
	logic tick;
	modport ctl (output restart, input tick);
	modport pre (input restart, output tick);
endinterface : wss_tick_if

// file: hdl/wss_prescaler.sv
// prescaler producing one enable pulse per delay unit
// assumes restart is asserted for one cycle at the start of a delay
`timescale 1ns/1ps
`include "wss_consts.svh"
module wss_prescaler #(
	parameter int unsigned UNIT_CYC = `WSS_UNIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// sequencer side
	wss_tick_if.pre  tk
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		if (tk.restart) begin
			nxt_cnt = 32'h00000000;
		end else if (cnt_ff == UNIT_CYC - 32'h00000001) begin
			nxt_cnt  = 32'h00000000;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff  <= 32'h00000000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tk.tick = tick_ff;
endmodule : wss_prescaler

// file: hdl/wss_top.sv
// sequencer walking the eight playback entries, owning entries three and four
// assumes the other six entries come from the surrounding register file
// and that the effect library answers each start with a done pulse
`timescale 1ns/1ps
`include "wss_consts.svh"
module wss_top
	import wss_pkg::*;
#(
	parameter int unsigned UNIT_CYC = `WSS_UNIT_CYC
) (
	// clock and reset
	input  wire  logic        sys_clk,
	input  wire  logic        rst,
	// register port
	input  wire  logic [7:0]  reg_addr,
	input  wire  logic        reg_wr_en,
	input  wire  logic [7:0]  reg_wr_data,
	output logic       [7:0]  reg_rd_data,
	// other six entries, index = address minus first address
	input  wire  logic [63:0] ext_entries,
	// trigger
	input  wire  logic        go,
	// effect library
	output logic              effect_start,
	output logic       [6:0]  effect_index,
	input  wire  logic        effect_done,
	// status
	output logic              busy,
	output logic              idling,
	output logic       [7:0]  cur_addr
);
	wss_state_t  st_ff;
	wss_state_t  nxt_st;
	wss_entry_t  entry3_ff;
	wss_entry_t  nxt_entry3;
	wss_entry_t  entry4_ff;
	wss_entry_t  nxt_entry4;
	logic [7:0]  rd_ff;
	logic [7:0]  nxt_rd;
	logic [7:0]  addr_ff;
	logic [7:0]  nxt_addr;
	logic [6:0]  wait_cnt_ff;
	logic [6:0]  nxt_wait_cnt;
	logic [6:0]  index_ff;
	logic [6:0]  nxt_index;
	logic        start_ff;
	logic        nxt_start;
	wss_entry_t  table_w [8];
	wss_entry_t  cur_entry;
	logic [2:0]  slot;
	logic        entry3_delay_flag;
	logic [6:0]  entry3_effect_index;
	logic        entry4_delay_flag;
	logic [6:0]  entry4_effect_index;
	logic        advance;
	logic        at_last;

	wss_tick_if tk ();

	wss_prescaler #(
		.UNIT_CYC (UNIT_CYC)
	) u_pre (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tk      (tk)
	);

	assign entry3_delay_flag   = entry3_ff[`WSS_FLAG_BIT];
	assign entry3_effect_index = entry3_ff[6:0];
	assign entry4_delay_flag   = entry4_ff[`WSS_FLAG_BIT];
	assign entry4_effect_index = entry4_ff[6:0];

	// entry table, own slots replace the outside ones
	for (genvar g = 0; g < 8; g++) begin : g_tab
		if (g == 2) begin : g_e3
			assign table_w[g] = {entry3_delay_flag, entry3_effect_index};
		end else if (g == 3) begin : g_e4
			assign table_w[g] = {entry4_delay_flag, entry4_effect_index};
		end else begin : g_ext
			assign table_w[g] = ext_entries[g*8 +: 8];
		end
	end

	assign slot      = 3'(addr_ff - `WSS_ADDR_FIRST);
	assign cur_entry = table_w[slot];
	assign at_last   = (addr_ff == `WSS_ADDR_LAST);

	// register file: writes and read-back
	always_comb begin
		nxt_entry3 = entry3_ff;
		nxt_entry4 = entry4_ff;
		if (reg_wr_en && reg_addr == `WSS_ADDR_ENTRY3) begin
			nxt_entry3 = reg_wr_data;
		end
		if (reg_wr_en && reg_addr == `WSS_ADDR_ENTRY4) begin
			nxt_entry4 = reg_wr_data;
		end
		unique case (reg_addr)
			`WSS_ADDR_ENTRY3: nxt_rd = entry3_ff;
			`WSS_ADDR_ENTRY4: nxt_rd = entry4_ff;
			default:          nxt_rd = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			entry3_ff <= `WSS_ENTRY_RST;
			entry4_ff <= `WSS_ENTRY_RST;
			rd_ff     <= 8'h00;
		end else begin
			entry3_ff <= nxt_entry3;
			entry4_ff <= nxt_entry4;
			rd_ff     <= nxt_rd;
		end
	end

	// an entry ends on library done or on the last delay unit
	assign advance = (st_ff == WSS_PLAY && effect_done) ||
	                 (st_ff == WSS_WAIT && tk.tick && wait_cnt_ff == 7'h01);

	// restart only on entry to a delay, so each delay gets full units
	assign tk.restart = (st_ff == WSS_FETCH) && cur_entry[`WSS_FLAG_BIT] &&
	                    (cur_entry[6:0] != 7'h00);

	// sequencer
	always_comb begin
		nxt_st       = st_ff;
		nxt_addr     = addr_ff;
		nxt_wait_cnt = wait_cnt_ff;
		nxt_index    = index_ff;
		nxt_start    = 1'b0;
		unique case (st_ff)
			WSS_IDLE: begin
				if (go) begin
					nxt_addr = `WSS_ADDR_FIRST;
					nxt_st   = WSS_FETCH;
				end
			end
			WSS_FETCH: begin
				if (cur_entry[6:0] == 7'h00) begin
					nxt_st = WSS_IDLE;
				end else if (cur_entry[`WSS_FLAG_BIT]) begin
					nxt_wait_cnt = cur_entry[6:0];
					nxt_st       = WSS_WAIT;
				end else begin
					nxt_index = cur_entry[6:0];
					nxt_start = 1'b1;
					nxt_st    = WSS_PLAY;
				end
			end
			WSS_PLAY, WSS_WAIT: begin
				if (st_ff == WSS_WAIT && tk.tick) begin
					nxt_wait_cnt = wait_cnt_ff - 7'h01;
				end
				if (advance) begin
					if (at_last) begin
						nxt_st = WSS_IDLE;
					end else begin
						nxt_addr = addr_ff + 8'h01;
						nxt_st   = WSS_FETCH;
					end
				end
			end
			default: begin
				nxt_st = WSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff       <= WSS_IDLE;
			addr_ff     <= `WSS_ADDR_FIRST;
			wait_cnt_ff <= 7'h00;
			index_ff    <= 7'h00;
			start_ff    <= 1'b0;
		end else begin
			st_ff       <= nxt_st;
			addr_ff     <= nxt_addr;
			wait_cnt_ff <= nxt_wait_cnt;
			index_ff    <= nxt_index;
			start_ff    <= nxt_start;
		end
	end

	assign reg_rd_data  = rd_ff;
	assign effect_start = start_ff;
	assign effect_index = index_ff;
	assign busy         = (st_ff != WSS_IDLE);
	assign idling       = (st_ff == WSS_WAIT);
	assign cur_addr     = addr_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_delay_no_effect: assert property (
		st_ff == WSS_WAIT |-> !effect_start && !start_ff)
		else $error("effect started during a delay entry");
	chk_delay_units: assert property (
		st_ff == WSS_FETCH && cur_entry[`WSS_FLAG_BIT] && cur_entry[6:0] != 7'h00
		|=> st_ff == WSS_WAIT && wait_cnt_ff == $past(cur_entry[6:0]))
		else $error("delay count not loaded from field");
	chk_delay_end: assert property (
		st_ff == WSS_WAIT && tk.tick && wait_cnt_ff == 7'h01 |=> st_ff != WSS_WAIT)
		else $error("delay did not end on last unit");
	chk_effect_pick: assert property (
		st_ff == WSS_FETCH && !cur_entry[`WSS_FLAG_BIT] && cur_entry[6:0] != 7'h00
		|=> effect_start && effect_index == $past(cur_entry[6:0]) ##1 !effect_start)
		else $error("effect index not issued");
	chk_start_first: assert property (
		st_ff == WSS_IDLE && go |=> st_ff == WSS_FETCH && addr_ff == `WSS_ADDR_FIRST)
		else $error("playback did not start at first entry");
	chk_next_addr: assert property (
		advance && !at_last |=> st_ff == WSS_FETCH && addr_ff == $past(addr_ff) + 8'h01)
		else $error("sequencer did not advance");
	chk_last_stop: assert property (
		advance && at_last |=> st_ff == WSS_IDLE)
		else $error("playback ran past last entry");
	chk_zero_stop: assert property (
		st_ff == WSS_FETCH && cur_entry[6:0] == 7'h00 |=> st_ff == WSS_IDLE && !effect_start)
		else $error("zero entry did not stop playback");
	chk_unit_restart: assert property (
		st_ff == WSS_FETCH && cur_entry[`WSS_FLAG_BIT] && cur_entry[6:0] != 7'h00
		|-> tk.restart ##1 !tk.tick)
		else $error("prescaler not restarted");

	cov_delay: cover property (st_ff == WSS_WAIT ##1 st_ff == WSS_FETCH);
	cov_play: cover property (effect_start ##[1:50] effect_done);
	cov_full_run: cover property (advance && at_last);
	cov_zero: cover property (st_ff == WSS_FETCH && cur_entry == 8'h00);
endmodule : wss_top

// file: testbench/tb_waveform_sequence_slots.sv
// self-checking bench for wss_top: register port, effect walk, delays, stops
// assumes wss_top elaborates with a short delay unit; bench plays the effect library
`timescale 1ns/1ps
`include "wss_consts.svh"
module tb_waveform_sequence_slots
	import wss_pkg::*;
;
	localparam int U = 4;
	logic        sys_clk, rst, reg_wr_en, go, effect_start, busy, idling;
	logic        effect_done = 1'b0;
	logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, cur_addr;
	logic [63:0] ext_entries;
	logic [6:0]  effect_index;
	logic [1:0]  dly = 2'b00;
	int          miscompares, n_checks, run_len;
	wss_entry_t  idx_q[$];
	int          idle_q[$];

	wss_top #(.UNIT_CYC(U)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .ext_entries(ext_entries), .go(go),
		.effect_start(effect_start), .effect_index(effect_index), .effect_done(effect_done),
		.busy(busy), .idling(idling), .cur_addr(cur_addr));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// library stand-in: answers each start three cycles later, logs indices and idle runs
	always @(posedge sys_clk) begin
		dly <= {dly[0], effect_start};
		effect_done <= dly[1];
		if (effect_start === 1'b1) begin
			idx_q.push_back({1'b0, effect_index});
		end
		if (idling === 1'b1) begin
			run_len <= run_len + 1;
		end else if (run_len != 0) begin
			idle_q.push_back(run_len);
			run_len <= 0;
		end
	end

	task automatic judge(input bit ok, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (!ok) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : judge

	task automatic check(input logic [31:0] e, input logic [31:0] g);
		judge(g === e, e, g);
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		// let an edge pass so a following write never re-raises the strobe in this step
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		@(posedge sys_clk);
		#1 check(e, reg_rd_data);
		@(posedge sys_clk);
	endtask : rd

	// one playback from go to stop, then compare effects and idle spans
	task automatic run(input wss_entry_t ei[$], input int eu[$]);
		idx_q = {};
		idle_q = {};
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		#1 check(1'b1, busy);
		check(`WSS_ADDR_FIRST, cur_addr);
		for (int i = 0; i < 3000; i++) begin
			@(posedge sys_clk);
			#1 if (busy === 1'b0) break;
		end
		check(1'b0, busy);
		@(posedge sys_clk);
		check(ei.size(), idx_q.size());
		foreach (ei[i]) check(ei[i], (i < idx_q.size()) ? idx_q[i] : 8'hFF);
		check(eu.size(), idle_q.size());
		foreach (eu[i]) judge(i < idle_q.size() && idle_q[i] >= eu[i] * U && idle_q[i] <= eu[i] * U + 2,
			eu[i] * U, (i < idle_q.size()) ? idle_q[i] : 0);
	endtask : run

	task automatic t_regs();
		rd(`WSS_ADDR_ENTRY3, 8'h00);
		rd(`WSS_ADDR_ENTRY4, 8'h00);
		check(8'h0F, cur_addr);
		wr(`WSS_ADDR_ENTRY3, 8'h85);
		wr(`WSS_ADDR_ENTRY4, 8'h3C);
		wr(8'h13, 8'hAA);
		rd(`WSS_ADDR_ENTRY3, 8'h85);
		rd(`WSS_ADDR_ENTRY4, 8'h3C);
		rd(8'h13, 8'h00);
		$display("test regs done");
	endtask : t_regs

	// all eight entries live: effects and delays mixed, ends after the last address
	task automatic t_full();
		ext_entries <= 64'h4433_2211_0000_8105;
		wr(`WSS_ADDR_ENTRY3, 8'h07);
		wr(`WSS_ADDR_ENTRY4, 8'h82);
		run('{8'h05, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44}, '{1, 2});
		$display("test full sequence done");
	endtask : t_full

	// zero field stops at entry three, with and without the delay flag
	task automatic t_stop();
		wr(`WSS_ADDR_ENTRY4, 8'h09);
		wr(`WSS_ADDR_ENTRY3, 8'h80);
		run('{8'h05}, '{1});
		wr(`WSS_ADDR_ENTRY3, 8'h00);
		run('{8'h05}, '{1});
		$display("test stop done");
	endtask : t_stop

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		ext_entries = 64'h0;
		go = 1'b0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_regs();
		t_full();
		t_stop();
		close_out();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		close_out();
	end
endmodule : tb_waveform_sequence_slots
